// >>> vsync_gen.sv
`timescale 1ns/1ns
module vsync_gen
  import vsync_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        pix_en,
  input  wire logic        field2,
  input  wire logic [11:0] frame_line_counter,
  input  wire logic [11:0] frame_pixel_counter,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             vsync
);
  logic [31:0] f1_start_ff, f1_stop_ff, f2_start_ff, f2_stop_ff;
  logic [31:0] nxt_f1_start, nxt_f1_stop, nxt_f2_start, nxt_f2_stop;
  logic        wr_pend_ff, nxt_wr_pend;
  logic [3:0]  wr_ofs_ff, nxt_wr_ofs;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic        vsync_ff, nxt_vsync;
  logic        hreadyout_ff, nxt_hreadyout;
  logic        hresp_ff, nxt_hresp;
  logic        take;
  vsync_cmp_if cif ();

  function automatic logic [31:0] keep_fields(input logic [31:0] v);
    return v & FIELD_MASK;
  endfunction : keep_fields

  assign take = hsel && hready && (htrans == HTRANS_NONSEQ) && (hsize == HSIZE_WORD);

  always_comb begin
    nxt_wr_pend  = take && hwrite;
    nxt_wr_ofs   = take ? haddr[3:0] : wr_ofs_ff;
    nxt_hrdata   = hrdata_ff;
    nxt_hreadyout = 1'b1;
    nxt_hresp    = 1'b0;
    nxt_f1_start = f1_start_ff;
    nxt_f1_stop  = f1_stop_ff;
    nxt_f2_start = f2_start_ff;
    nxt_f2_stop  = f2_stop_ff;
    if (wr_pend_ff) begin
      unique case (wr_ofs_ff)
        OFS_F1_START: nxt_f1_start = keep_fields(hwdata);
        OFS_F1_STOP:  nxt_f1_stop  = keep_fields(hwdata);
        OFS_F2_START: nxt_f2_start = keep_fields(hwdata);
        OFS_F2_STOP:  nxt_f2_stop  = keep_fields(hwdata);
        default: ;
      endcase
    end
    // reads see a write that is still in its data phase
    if (take && !hwrite) begin
      unique case (haddr[3:0])
        OFS_F1_START: nxt_hrdata = nxt_f1_start;
        OFS_F1_STOP:  nxt_hrdata = nxt_f1_stop;
        OFS_F2_START: nxt_hrdata = nxt_f2_start;
        OFS_F2_STOP:  nxt_hrdata = nxt_f2_stop;
        default:      nxt_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      f1_start_ff <= POS_RESET;
      f1_stop_ff  <= POS_RESET;
      f2_start_ff <= POS_RESET;
      f2_stop_ff  <= POS_RESET;
      wr_pend_ff  <= 1'b0;
      wr_ofs_ff   <= 4'h0;
      hrdata_ff   <= 32'h0000_0000;
      hreadyout_ff <= 1'b1;
      hresp_ff    <= 1'b0;
    end else begin
      f1_start_ff <= nxt_f1_start;
      f1_stop_ff  <= nxt_f1_stop;
      f2_start_ff <= nxt_f2_start;
      f2_stop_ff  <= nxt_f2_stop;
      wr_pend_ff  <= nxt_wr_pend;
      wr_ofs_ff   <= nxt_wr_ofs;
      hrdata_ff   <= nxt_hrdata;
      hreadyout_ff <= nxt_hreadyout;
      hresp_ff    <= nxt_hresp;
    end
  end

  assign hrdata    = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp     = hresp_ff;

  // per-field position selection
  assign cif.start_pos = field2 ? f2_start_ff : f1_start_ff;
  assign cif.stop_pos  = field2 ? f2_stop_ff : f1_stop_ff;
  assign cif.line_cnt  = frame_line_counter;
  assign cif.pix_cnt   = frame_pixel_counter;

  vsync_cmp u_cmp (
    .c (cif.cmp)
  );

  // stop wins when start and stop coincide
  always_comb begin
    nxt_vsync = vsync_ff;
    if (pix_en) begin
      if (cif.hit_stop)
        nxt_vsync = 1'b0;
      else if (cif.hit_start)
        nxt_vsync = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b)
      vsync_ff <= 1'b0;
    else
      vsync_ff <= nxt_vsync;
  end

  assign vsync = vsync_ff;

  // independent position matches for the checks below
  logic f1_at_start, f1_at_stop, f2_at_start, f2_at_stop, addr_mapped;
  assign f1_at_start = frame_line_counter == f1_start_ff[LINE_LSB +: POS_W] &&
                       frame_pixel_counter == f1_start_ff[PIX_LSB +: POS_W];
  assign f1_at_stop  = frame_line_counter == f1_stop_ff[LINE_LSB +: POS_W] &&
                       frame_pixel_counter == f1_stop_ff[PIX_LSB +: POS_W];
  assign f2_at_start = frame_line_counter == f2_start_ff[LINE_LSB +: POS_W] &&
                       frame_pixel_counter == f2_start_ff[PIX_LSB +: POS_W];
  assign f2_at_stop  = frame_line_counter == f2_stop_ff[LINE_LSB +: POS_W] &&
                       frame_pixel_counter == f2_stop_ff[PIX_LSB +: POS_W];
  assign addr_mapped = haddr[3:0] inside {OFS_F1_START, OFS_F1_STOP, OFS_F2_START,
                                          OFS_F2_STOP};

  a_f2_start_sets: assert property (@(posedge clock) disable iff (!rst_b)
    pix_en && field2 && f2_at_start && !f2_at_stop
    |=> vsync)
    else $error("field 2 start did not raise sync");

  a_f2_stop_clears: assert property (@(posedge clock) disable iff (!rst_b)
    pix_en && field2 && f2_at_stop
    |=> !vsync)
    else $error("field 2 stop did not drop sync");

  a_f1_start_sets: assert property (@(posedge clock) disable iff (!rst_b)
    pix_en && !field2 && f1_at_start && !f1_at_stop
    |=> vsync)
    else $error("field 1 start did not raise sync");

  a_f1_stop_clears: assert property (@(posedge clock) disable iff (!rst_b)
    pix_en && !field2 && f1_at_stop
    |=> !vsync)
    else $error("field 1 stop did not drop sync");

  a_f2_field_gate: assert property (@(posedge clock) disable iff (!rst_b)
    pix_en && field2 && !f2_at_start && !f2_at_stop
    |=> $stable(vsync))
    else $error("sync moved in field 2 off its positions");

  a_f1_field_gate: assert property (@(posedge clock) disable iff (!rst_b)
    pix_en && !field2 && !f1_at_start && !f1_at_stop
    |=> $stable(vsync))
    else $error("sync moved in field 1 off its positions");

  a_sync_holds_idle: assert property (@(posedge clock) disable iff (!rst_b)
    !pix_en
    |=> $stable(vsync))
    else $error("sync moved without pixel enable");

  a_reserved_zero: assert property (@(posedge clock) disable iff (!rst_b)
    ((f1_start_ff | f1_stop_ff | f2_start_ff | f2_stop_ff) & ~FIELD_MASK)
    == 32'h0000_0000)
    else $error("reserved bits held nonzero");

  a_f2_start_write: assert property (@(posedge clock) disable iff (!rst_b)
    take && hwrite && haddr[3:0] == OFS_F2_START ##1 1'b1
    |=> f2_start_ff == ($past(hwdata) & FIELD_MASK))
    else $error("field 2 start write lost");

  a_f2_stop_write: assert property (@(posedge clock) disable iff (!rst_b)
    take && hwrite && haddr[3:0] == OFS_F2_STOP ##1 1'b1
    |=> f2_stop_ff == ($past(hwdata) & FIELD_MASK))
    else $error("field 2 stop write lost");

  a_f1_stop_write: assert property (@(posedge clock) disable iff (!rst_b)
    take && hwrite && haddr[3:0] == OFS_F1_STOP ##1 1'b1
    |=> f1_stop_ff[PIX_LSB +: POS_W] == $past(hwdata[PIX_LSB +: POS_W]))
    else $error("field 1 stop pixel write lost");

  a_f1_line_write: assert property (@(posedge clock) disable iff (!rst_b)
    take && hwrite && haddr[3:0] == OFS_F1_STOP ##1 1'b1
    |=> f1_stop_ff[LINE_LSB +: POS_W] == $past(hwdata[LINE_LSB +: POS_W]))
    else $error("field 1 stop line write lost");

  a_f1_start_write: assert property (@(posedge clock) disable iff (!rst_b)
    take && hwrite && haddr[3:0] == OFS_F1_START ##1 1'b1
    |=> f1_start_ff == ($past(hwdata) & FIELD_MASK))
    else $error("field 1 start write lost");

  a_read_f2_start: assert property (@(posedge clock) disable iff (!rst_b)
    take && !hwrite && !wr_pend_ff && haddr[3:0] == OFS_F2_START
    |=> hrdata == $past(f2_start_ff))
    else $error("field 2 start read wrong");

  a_read_f2_stop: assert property (@(posedge clock) disable iff (!rst_b)
    take && !hwrite && !wr_pend_ff && haddr[3:0] == OFS_F2_STOP
    |=> hrdata == $past(f2_stop_ff))
    else $error("field 2 stop read wrong");

  a_read_f1_stop: assert property (@(posedge clock) disable iff (!rst_b)
    take && !hwrite && !wr_pend_ff && haddr[3:0] == OFS_F1_STOP
    |=> hrdata == $past(f1_stop_ff))
    else $error("field 1 stop read wrong");

  a_unmapped_read: assert property (@(posedge clock) disable iff (!rst_b)
    take && !hwrite && !addr_mapped
    |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
endmodule : vsync_gen

// >>> vsync_pkg.sv
// Function
// - field 2 start line and pixel match asserts sync
// - field 2 stop line and pixel match deasserts sync
// - field 2 start line: bits 27-16, reset zero
// - field 2 start pixel: bits 11-0, reset zero
// - field 2 stop line: bits 27-16, reset zero
// - field 2 stop pixel: bits 11-0, reset zero
// - field 1 stop pixel: bits 11-0, reset zero
// - reserved bits read zero, writes ignored
// - field 1 start line and pixel match asserts sync
// - field 1 stop match deasserts sync, line bits 27-16
package vsync_pkg;
  localparam int          POS_W          = 12;
  localparam int          LINE_LSB       = 16;
  localparam int          PIX_LSB        = 0;
  localparam logic [31:0] FIELD_MASK     = 32'h0FFF_0FFF;
  localparam logic [31:0] POS_RESET      = 32'h0000_0000;
  localparam logic [3:0]  OFS_F1_START   = 4'h0;
  localparam logic [3:0]  OFS_F1_STOP    = 4'h4;
  localparam logic [3:0]  OFS_F2_START   = 4'h8;
  localparam logic [3:0]  OFS_F2_STOP    = 4'hC;
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
  localparam logic [2:0]  HSIZE_WORD     = 3'h2;
  localparam logic [1:0]  HTRANS_IDLE    = 2'h0;

  // true when the counters sit on the line and pixel of a position word
  function automatic logic pos_hit(input logic [31:0] pos,
                                   input logic [11:0] lc,
                                   input logic [11:0] pc);
    return (lc == pos[LINE_LSB +: POS_W]) && (pc == pos[PIX_LSB +: POS_W]);
  endfunction : pos_hit
endpackage : vsync_pkg

// >>> vsync_cmp_if.sv
`timescale 1ns/1ns
interface vsync_cmp_if;
  logic [31:0] start_pos;
  logic [31:0] stop_pos;
  logic [11:0] line_cnt;
  logic [11:0] pix_cnt;
  logic        hit_start;
  logic        hit_stop;
  modport cmp (input start_pos, stop_pos, line_cnt, pix_cnt, output hit_start, hit_stop);
  modport top (output start_pos, stop_pos, line_cnt, pix_cnt, input hit_start, hit_stop);
endinterface : vsync_cmp_if

// >>> vsync_cmp.sv
`timescale 1ns/1ns
module vsync_cmp
  import vsync_pkg::*;
(
  vsync_cmp_if.cmp c
);
  always_comb begin
    c.hit_start = pos_hit(c.start_pos, c.line_cnt, c.pix_cnt);
    c.hit_stop  = pos_hit(c.stop_pos, c.line_cnt, c.pix_cnt);
  end
endmodule : vsync_cmp

// >>> vsync_sink.sv
`timescale 1ns/1ns
module vsync_sink (
  input  wire logic clock,
  input  wire logic vsync,
  output int        pulses
);
  logic last_ff = 1'b0;
  initial pulses = 0;
  // counts sync pulses seen by the display
  always @(posedge clock) begin
    if (vsync === 1'b1 && last_ff !== 1'b1) pulses <= pulses + 1;
    last_ff <= vsync;
  end
endmodule : vsync_sink

// >>> tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import vsync_pkg::*;
  logic        clock, rst_b, pix_en, field2, hsel, hwrite;
  logic [11:0] line_c, pix_c;
  logic [31:0] haddr, hwdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, vsync;
  wire         hready = hreadyout;
  int          n_fail, checked, pulses;
  vsync_gen i_vsync_gen (.clock(clock), .rst_b(rst_b), .pix_en(pix_en), .field2(field2),
    .frame_line_counter(line_c), .frame_pixel_counter(pix_c), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .vsync(vsync));
  vsync_sink i_vsync_sink (.clock(clock), .vsync(vsync), .pulses(pulses));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task finish_test;
    $display("checked %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task wait_rdy;
    int i;
    for (i = 0; i < 20; i++) begin
      @(posedge clock);
      if (hready === 1'b1) break;
    end
    if (i == 20) begin
      n_fail++;
      finish_test;
    end
  endtask : wait_rdy
  task bus(input logic [3:0] a, input logic w, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {28'h000_0000, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    wait_rdy;
    htrans <= HTRANS_IDLE;
    hwdata <= d;
    wait_rdy;
    q = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : bus
  task rd(input logic [3:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk("hrdata", e, q);
  endtask : rd
  task px(input logic f, input logic [11:0] l, input logic [11:0] p, input logic e,
          input logic v);
    field2 <= f;
    line_c <= l;
    pix_c  <= p;
    pix_en <= e;
    @(posedge clock);
    pix_en <= 1'b0;
    @(posedge clock);
    chk("vsync", {31'h0, v}, {31'h0, vsync});
  endtask : px
  task t_regs;
    for (int k = 0; k < 4; k++) rd(4'(k * 4), POS_RESET);
    for (int k = 0; k < 4; k++) begin
      bus(4'(k * 4), 1'b1, 32'hFFFF_FFFF);
      rd(4'(k * 4), FIELD_MASK);
    end
    bus(OFS_F2_START, 1'b1, 32'h0123_0456);
    bus(OFS_F2_STOP, 1'b1, 32'h0123_0789);
    hsize <= 3'h0;
    bus(OFS_F2_START, 1'b1, 32'h0ABC_0DEF);
    hsize <= HSIZE_WORD;
    bus(4'h2, 1'b1, 32'hFFFF_FFFF);
    rd(4'h2, 32'h0000_0000);
    rd(OFS_F2_START, 32'h0123_0456);
    rd(OFS_F2_STOP, 32'h0123_0789);
    $display("t_regs done");
  endtask : t_regs
  task t_f2;
    px(1'b0, 12'h123, 12'h456, 1'b1, 1'b0);
    px(1'b1, 12'h123, 12'h455, 1'b1, 1'b0);
    px(1'b1, 12'h123, 12'h456, 1'b0, 1'b0);
    px(1'b1, 12'h123, 12'h456, 1'b1, 1'b1);
    px(1'b1, 12'h124, 12'h789, 1'b1, 1'b1);
    px(1'b1, 12'h123, 12'h789, 1'b1, 1'b0);
    $display("t_f2 done");
  endtask : t_f2
  task t_f1;
    bus(OFS_F1_START, 1'b1, 32'h0F00_0001);
    bus(OFS_F1_STOP, 1'b1, 32'h0000_0FFF);
    rd(OFS_F1_STOP, 32'h0000_0FFF);
    px(1'b0, 12'hF00, 12'h001, 1'b1, 1'b1);
    px(1'b1, 12'h000, 12'hFFF, 1'b1, 1'b1);
    px(1'b0, 12'h000, 12'hFFE, 1'b1, 1'b1);
    px(1'b0, 12'h000, 12'hFFF, 1'b1, 1'b0);
    chk("pulses", 32'h2, pulses);
    $display("t_f1 done");
  endtask : t_f1
  task t_rst;
    px(1'b0, 12'hF00, 12'h001, 1'b1, 1'b1);
    rst_b <= 1'b0;
    @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    chk("vsync", 32'h0, {31'h0, vsync});
    rd(OFS_F1_START, POS_RESET);
    px(1'b0, 12'hF00, 12'h001, 1'b1, 1'b0);
    chk("pulses", 32'h3, pulses);
    $display("t_rst done");
  endtask : t_rst
  initial begin
    rst_b   = 1'b0;
    pix_en  = 1'b0;
    field2  = 1'b0;
    hsel    = 1'b0;
    hwrite  = 1'b0;
    line_c  = 12'h000;
    pix_c   = 12'h000;
    haddr   = 32'h0000_0000;
    hwdata  = 32'h0000_0000;
    htrans  = HTRANS_IDLE;
    hsize   = HSIZE_WORD;
    n_fail  = 0;
    checked = 0;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    t_regs;
    t_f2;
    t_f1;
    t_rst;
    finish_test;
  end
endmodule : tb_top
